// ---- common/sbpm_map.svh ----
// Behaviour
// - Operation is the same in normal, special and emulation chip modes.
// - With halt_in_wait clear the block runs normally during CPU wait.
// - halt_in_wait set: wait stops clock generation; tx_on, rx_on keep values.
// - Frames freeze on wait entry and continue after an interrupt ends wait.
// - Leaving wait or stop by reset aborts frames and resets everything.
// - Stop gates the block off, keeps registers, resumes after wake.
// - Transmit pin idles high and floats while transmitter is disabled.
// - Receive pin high means idle; ignored while receiver is disabled.
// - Reserved locations ignore writes and read as zero; control_one and control_two store and read back all eight bits.
// - Baud high bit 7 switches the infrared path on or off.
// - Normal mode: baud equals module clock over 16 times divisor.
// - Infrared mode: baud is module clock over 32 times divisor bits 12:1.
// - Pulse select 00 is 3/16, 01 is 1/16, 10 is 1/32; 11 reserved.
// - Generator stays stopped after reset until tx_on or rx_on first set.
// - Generator disabled when the used divisor bits are all zero.
// - Baud high write is staged; it takes effect when baud low is written.
// - halt_in_wait is control_one bit 6; one disables in wait.
`ifndef SBPM_MAP_SVH
`define SBPM_MAP_SVH
`define SBPM_OFF_BAUD_HIGH   12'h000
`define SBPM_OFF_BAUD_LOW    12'h004
`define SBPM_OFF_CONTROL_ONE 12'h008
`define SBPM_OFF_CONTROL_TWO 12'h00C
`define SBPM_OFF_IRQ_STATUS  12'h010
`define SBPM_OFF_IRQ_MASK    12'h014
`define SBPM_OFF_GEN_STATUS  12'h018
`define SBPM_BIT_IR_ON       7
`define SBPM_BIT_HALT_WAIT   6
`define SBPM_BIT_TX_ON       3
`define SBPM_BIT_RX_ON       2
`define SBPM_RST_BYTE        8'h00
`define SBPM_IRQ_TICK        0
`define SBPM_IRQ_RX_EDGE     1
`define SBPM_IRQ_FREEZE      2
`define SBPM_IRQ_BITS        3
`endif

// ---- common/sbpm_pkg.sv ----
package sbpm_pkg;
  typedef enum logic [1:0] {
    SBPM_PULSE_3_16,
    SBPM_PULSE_1_16,
    SBPM_PULSE_1_32,
    SBPM_PULSE_RSVD
  } sbpm_pulse_t;
  typedef enum logic [1:0] {
    SBPM_RUN,
    SBPM_FROZEN,
    SBPM_STOPPED
  } sbpm_power_t;
endpackage

// ---- logic/sbpm_top.sv ----
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "sbpm_map.svh"
module sbpm_top #(
  parameter int DIV_W = 13
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        CPU_WAIT,
  input  wire logic        CPU_STOP,
  input  wire logic        SERIAL_IN_PIN,
  output logic             SERIAL_OUT_PIN,
  output logic             SERIAL_OUT_OE,
  output logic             SERIAL_IN_IDLE,
  output logic             SAMPLE_TICK,
  output logic             BIT_TICK,
  output logic             IR_ON,
  output logic      [4:0]  PULSE_TICKS32,
  output logic             IRQ
);

  // Control and baud state
  logic [7:0]       baud_high;
  logic [7:0]       baud_low;
  logic [7:0]       staged_high;
  logic [7:0]       control_one;
  logic [7:0]       control_two;
  logic [`SBPM_IRQ_BITS-1:0] irq_status;
  logic [`SBPM_IRQ_BITS-1:0] irq_mask;
  logic             gen_started;
  logic [DIV_W-1:0] tick_count;
  logic [3:0]       tick_phase;
  logic [2:0]       rx_sync;
  logic             rx_level;
  sbpm_pkg::sbpm_power_t power;
  sbpm_pkg::sbpm_power_t next_power;

  // APB decode; one-cycle answer, no wait states
  logic wr_en;
  logic rd_en;
  logic byte_en;
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && PENABLE && !PWRITE;
  assign byte_en = PSTRB[0];
  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0; // Unmapped reads zero instead of erroring

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  logic tx_on;
  logic rx_on;
  logic ir_mode;
  logic halt_wait;
  logic [DIV_W-1:0] divisor;
  logic [DIV_W-1:0] period;
  logic gen_run;
  assign tx_on     = control_two[`SBPM_BIT_TX_ON];
  assign rx_on     = control_two[`SBPM_BIT_RX_ON];
  assign ir_mode   = baud_high[`SBPM_BIT_IR_ON];
  assign halt_wait = control_one[`SBPM_BIT_HALT_WAIT];
  assign divisor   = {baud_high[4:0], baud_low};
  // IR clears divisor bit 0, so the period is twice divisor bits 12:1
  assign period    = ir_mode ? {divisor[DIV_W-1:1], 1'b0} : divisor;
  assign gen_run   = gen_started && (period != '0) &&
                     (power == sbpm_pkg::SBPM_RUN);

  // Power state: wait freezes only when halt_in_wait set; stop always
  always_comb begin
    if (CPU_STOP) begin
      next_power = sbpm_pkg::SBPM_STOPPED;
    end else if (CPU_WAIT && halt_wait) begin
      next_power = sbpm_pkg::SBPM_FROZEN;
    end else begin
      next_power = sbpm_pkg::SBPM_RUN;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      power <= sbpm_pkg::SBPM_RUN;
    end else begin
      power <= next_power;
    end
  end

  // Register writes; registers keep contents through wait and stop
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      baud_high   <= `SBPM_RST_BYTE;
      baud_low    <= `SBPM_RST_BYTE;
      staged_high <= `SBPM_RST_BYTE;
      control_one <= `SBPM_RST_BYTE;
      control_two <= `SBPM_RST_BYTE;
      irq_mask    <= '0;
    end else if (wr_en && byte_en) begin
      if (hit(PADDR, `SBPM_OFF_BAUD_HIGH)) begin
        staged_high <= PWDATA[7:0];
      end
      if (hit(PADDR, `SBPM_OFF_BAUD_LOW)) begin
        baud_low  <= PWDATA[7:0];
        baud_high <= staged_high;
      end
      if (hit(PADDR, `SBPM_OFF_CONTROL_ONE)) begin
        control_one <= PWDATA[7:0];
      end
      if (hit(PADDR, `SBPM_OFF_CONTROL_TWO)) begin
        control_two <= PWDATA[7:0]; // bits untouched by wait
      end
      if (hit(PADDR, `SBPM_OFF_IRQ_MASK)) begin
        irq_mask <= PWDATA[`SBPM_IRQ_BITS-1:0];
      end
    end
  end

  // Generator stays off after reset until a first enable
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      gen_started <= 1'b0;
    end else if (tx_on || rx_on) begin
      gen_started <= 1'b1;
    end
  end

  // Divider: one sample tick per period, bit tick every sixteenth
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      tick_count  <= '0;
      tick_phase  <= '0;
      SAMPLE_TICK <= 1'b0;
      BIT_TICK    <= 1'b0;
    end else if (!gen_run) begin
      SAMPLE_TICK <= 1'b0; // Counts hold so a frozen frame resumes
      BIT_TICK    <= 1'b0;
    end else if (tick_count >= period - 1'b1) begin
      tick_count  <= '0;
      tick_phase  <= tick_phase + 4'h1;
      SAMPLE_TICK <= 1'b1;
      BIT_TICK    <= (tick_phase == 4'hF);
    end else begin
      tick_count  <= tick_count + 1'b1;
      SAMPLE_TICK <= 1'b0;
      BIT_TICK    <= 1'b0;
    end
  end

  // Receive pin: three flops, change accepted when last two agree
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      rx_sync  <= 3'h7;
      rx_level <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], SERIAL_IN_PIN};
      if (rx_sync[2] == rx_sync[1]) begin
        rx_level <= rx_sync[2];
      end
    end
  end

  // Idle seen only while receiver is on; else forced idle
  assign SERIAL_IN_IDLE = rx_on ? rx_level : 1'b1;

  // Transmit pin rests high; floats when transmitter off
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      SERIAL_OUT_PIN <= 1'b1;
      SERIAL_OUT_OE  <= 1'b0;
    end else begin
      SERIAL_OUT_PIN <= 1'b1;
      SERIAL_OUT_OE  <= tx_on;
    end
  end

  // Pulse width in thirty-seconds of a bit; reserved code gives none
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      IR_ON         <= 1'b0;
      PULSE_TICKS32 <= 5'h06;
    end else begin
      IR_ON <= ir_mode;
      case (sbpm_pkg::sbpm_pulse_t'(baud_high[6:5]))
        sbpm_pkg::SBPM_PULSE_3_16: PULSE_TICKS32 <= 5'h06;
        sbpm_pkg::SBPM_PULSE_1_16: PULSE_TICKS32 <= 5'h02;
        sbpm_pkg::SBPM_PULSE_1_32: PULSE_TICKS32 <= 5'h01;
        default:                   PULSE_TICKS32 <= 5'h00;
      endcase
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  logic [`SBPM_IRQ_BITS-1:0] events;
  logic [`SBPM_IRQ_BITS-1:0] clr;
  assign events = {(next_power == sbpm_pkg::SBPM_FROZEN) &&
                   (power == sbpm_pkg::SBPM_RUN),
                   rx_on && !rx_level && SERIAL_IN_IDLE,
                   BIT_TICK};
  assign clr = (wr_en && byte_en && hit(PADDR, `SBPM_OFF_IRQ_STATUS)) ?
               PWDATA[`SBPM_IRQ_BITS-1:0] : '0;
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~clr) | events;
    end
  end
  assign IRQ = |(irq_status & irq_mask);

  // Read mux; baud high reads the live value, not the staged one
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        `SBPM_OFF_BAUD_HIGH:   PRDATA <= {24'h0, baud_high};
        `SBPM_OFF_BAUD_LOW:    PRDATA <= {24'h0, baud_low};
        `SBPM_OFF_CONTROL_ONE: PRDATA <= {24'h0, control_one};
        `SBPM_OFF_CONTROL_TWO: PRDATA <= {24'h0, control_two};
        `SBPM_OFF_IRQ_STATUS:  PRDATA <= {29'h0, irq_status};
        `SBPM_OFF_IRQ_MASK:    PRDATA <= {29'h0, irq_mask};
        `SBPM_OFF_GEN_STATUS:  PRDATA <= {28'h0, power, gen_started, gen_run};
        default:               PRDATA <= '0;
      endcase
    end
  end

  logic unused_ok;
  assign unused_ok = rd_en;
endmodule
`default_nettype wire

// ---- sim/sbpm_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module sbpm_asserts (
  input wire logic        REF_CLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        CPU_STOP,
  input wire logic        SERIAL_OUT_PIN,
  input wire logic        SERIAL_OUT_OE,
  input wire logic        SAMPLE_TICK,
  input wire logic        BIT_TICK,
  input wire logic        IR_ON,
  input wire logic [4:0]  PULSE_TICKS32,
  input wire logic        IRQ
);
  logic [4:0] scnt;
  wire        wlow = PSEL && PENABLE && PWRITE && PADDR == 12'h004;
  // Sample ticks since the last bit tick; saturates so it cannot wrap
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET || BIT_TICK) scnt <= 5'h00;
    else if (SAMPLE_TICK && scnt != 5'h1F) scnt <= scnt + 5'h01;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  out_idle_a: assert property (SERIAL_OUT_PIN)
    else $error("serial out left idle level");
  pulse_code_a: assert property (PULSE_TICKS32 inside {6, 2, 1, 0})
    else $error("pulse width code off table");
  slave_ok_a: assert property (PREADY && !PSLVERR)
    else $error("bus answer not ready or error");
  bit_gap_a: assert property (scnt <= 5'h10)
    else $error("more than sixteen ticks per bit");
  stop_hold_a: assert property (CPU_STOP [*3] |->
    !SAMPLE_TICK && !BIT_TICK)
    else $error("ticks during stop");
  reset_quiet_a: assert property ($fell(RESET) |->
    !IRQ && !SAMPLE_TICK && !SERIAL_OUT_OE)
    else $error("block active right after reset");
  unmapped_zero_a: assert property (PSEL && !PENABLE && !PWRITE &&
    PADDR > 12'h018 |=> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  ir_stage_a: assert property ($changed(IR_ON) |->
    $past(wlow) || $past(wlow, 2))
    else $error("infrared mode changed without low byte write");
  cover property (IR_ON && SAMPLE_TICK);
  cover property (IRQ);
  cover property (CPU_STOP && SERIAL_OUT_OE);
endmodule
bind sbpm_top sbpm_asserts u_chk (.*);
`default_nettype wire

// ---- sim/sbpm_remote.sv ----
`timescale 1ns/1ns
`default_nettype none
module sbpm_remote (
  input  wire logic drive_low,
  output logic      line
);
  // Line is terminated high; low only while a space is sent
  assign line = !drive_low;
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sbpm_map.svh"
module tb;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  logic wt = 0, stp = 0, lo = 0;
  logic [11:0] pa = '0;
  logic [31:0] pd = '0, prd;
  logic rdy, oe, idl, st, bt, ir, irq, line;
  logic [4:0] pw32;
  logic [4:0] pe [4] = '{5'h06, 5'h02, 5'h01, 5'h00};
  int err_total = 0, n_checks = 0, n;
  // 20 MHz reference clock
  always #25 clk = ~clk;
  sbpm_top dut (.REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pd), .PSTRB(4'hF), .PRDATA(prd),
    .PREADY(rdy), .PSLVERR(), .CPU_WAIT(wt), .CPU_STOP(stp),
    .SERIAL_IN_PIN(line), .SERIAL_OUT_PIN(), .SERIAL_OUT_OE(oe),
    .SERIAL_IN_IDLE(idl), .SAMPLE_TICK(st), .BIT_TICK(bt), .IR_ON(ir),
    .PULSE_TICKS32(pw32), .IRQ(irq));
  sbpm_remote peer (.drive_low(lo), .line(line));
  task automatic chk(input string nm, input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // Request held until ready is seen high at a rising edge
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk) {psel, pwr, pa, pd} <= {1'b1, w, a, d};
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q = prd;
    {psel, pen} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  // Cycles between two pulses, sampled on the quiet edge
  task automatic gap(input bit b, output int k);
    for (int i = 0; i < 3000 && (b ? bt : st) !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    for (k = 1; k < 3000 && (b ? bt : st) !== 1'b1; k++) @(negedge clk);
  endtask
  // Sample ticks in a 40-cycle window, after settling
  task automatic cnt(output int k);
    k = 0;
    repeat (3) @(negedge clk);
    repeat (40) begin
      @(negedge clk);
      if (st === 1'b1) k++;
    end
  endtask
  task automatic t_reset;
    rdc("baud_high", `SBPM_OFF_BAUD_HIGH, 32'h0);
    wr(12'h040, 32'hFFFF_FFFF);
    rdc("unmapped", 12'h040, 32'h0);
    wr(`SBPM_OFF_CONTROL_ONE, 32'hFFFF_0040);
    rdc("control_one", `SBPM_OFF_CONTROL_ONE, 32'h40);
    wr(`SBPM_OFF_BAUD_LOW, 32'h05);
    cnt(n); chk("ticks before enable", n, 0);
    wr(`SBPM_OFF_CONTROL_TWO, 32'h08);
    repeat (2) @(negedge clk);
    chk("oe", oe, 1);
    gap(0, n); chk("sample period", n, 5);
    gap(1, n); chk("bit period", n, 80);
  endtask
  task automatic t_ir;
    wr(`SBPM_OFF_BAUD_HIGH, 32'h80);
    rdc("staged high", `SBPM_OFF_BAUD_HIGH, 32'h0);
    chk("ir staged", ir, 0);
    for (int i = 0; i < 4; i++) begin
      wr(`SBPM_OFF_BAUD_HIGH, 32'h80 | (i << 5));
      wr(`SBPM_OFF_BAUD_LOW, 32'h06);
      repeat (2) @(negedge clk);
      chk("pulse width", pw32, pe[i]);
    end
    chk("ir on", ir, 1);
    gap(0, n); chk("ir period", n, 6);
    wr(`SBPM_OFF_BAUD_LOW, 32'h01);
    cnt(n); chk("ir zero divisor", n, 0);
    wr(`SBPM_OFF_BAUD_HIGH, 32'h0);
    wr(`SBPM_OFF_BAUD_LOW, 32'h05);
    repeat (2) @(negedge clk);
    chk("ir off", ir, 0);
  endtask
  task automatic t_power;
    wr(`SBPM_OFF_CONTROL_ONE, 32'h0);
    @(posedge clk) wt <= 1'b1;
    cnt(n); chk("wait running", n, 8);
    @(posedge clk) wt <= 1'b0;
    wr(`SBPM_OFF_CONTROL_ONE, 32'h40);
    wr(`SBPM_OFF_IRQ_STATUS, 32'h7);
    @(posedge clk) wt <= 1'b1;
    cnt(n); chk("wait halted", n, 0);
    chk("oe kept", oe, 1);
    @(posedge clk) wt <= 1'b0;
    gap(0, n); chk("resume period", n, 5);
    gap(1, n); chk("resume bit period", n, 80);
    rdc("freeze flag", `SBPM_OFF_IRQ_STATUS, 32'h5);
    @(posedge clk) stp <= 1'b1;
    cnt(n); chk("stop ticks", n, 0);
    @(posedge clk) stp <= 1'b0;
    rdc("kept low", `SBPM_OFF_BAUD_LOW, 32'h05);
  endtask
  task automatic t_irq;
    wr(`SBPM_OFF_IRQ_MASK, 32'h0);
    @(negedge clk) chk("irq masked", irq, 0);
    wr(`SBPM_OFF_IRQ_MASK, 32'h4);
    @(negedge clk) chk("irq raised", irq, 1);
    wr(`SBPM_OFF_IRQ_STATUS, 32'h4);
    @(negedge clk) chk("irq cleared", irq, 0);
  endtask
  task automatic t_rx;
    @(posedge clk) lo <= 1'b1;
    repeat (6) @(negedge clk);
    chk("rx off idle", idl, 1);
    wr(`SBPM_OFF_CONTROL_TWO, 32'h0C);
    repeat (6) @(negedge clk);
    chk("rx low", idl, 0);
    @(posedge clk) lo <= 1'b0;
    repeat (6) @(negedge clk);
    chk("rx idle", idl, 1);
  endtask
  task automatic t_rst;
    @(posedge clk) {rst, wt} <= 2'b11;
    @(negedge clk) chk("oe in reset", oe, 0);
    @(posedge clk) {rst, wt} <= 2'b00;
    rdc("control_two", `SBPM_OFF_CONTROL_TWO, 32'h0);
    rdc("baud_low", `SBPM_OFF_BAUD_LOW, 32'(`SBPM_RST_BYTE));
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence, reset held for three cycles
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset; t_ir; t_power; t_irq; t_rx; t_rst;
    final_report;
  end
  // Hang guard, well beyond the expected run
  initial begin
    #2000000;
    err_total++;
    final_report;
  end
endmodule
`default_nettype wire
